// File: design/pmio_params.svh
// constants for the power manager io port control logic
// included by the package user modules; no code here
`ifndef PMIO_PARAMS_SVH
`define PMIO_PARAMS_SVH
`define PMIO_CLK_HZ 10000000
`define PMIO_KEY_PRESS_MS 2000
`define PMIO_LONG_PRESS_SHUTDOWN_TIME_MS 1000
`define PMIO_ARM_WAIT_MS 1000
`define PMIO_MONITOR_RESET_EN_MS 1
`define PMIO_RST_MIN_MS 1
`define PMIO_RST_MAX_MS 1000
`define PMIO_CYC_PER_MS (`PMIO_CLK_HZ / 1000)
`define PMIO_DEB_CYCLES 16
`define PMIO_MODE_EDGE 2'h0
`define PMIO_MODE_LOCK 2'h1
`define PMIO_MODE_OFF 2'h2
`define PMIO_MODE_STBY 2'h3
`define PMIO_TRG_WAKE 2'h0
`define PMIO_TRG_SYSUP 2'h1
`define PMIO_TRG_PWRUP 2'h2
`define PMIO_TRG_LEAVE 2'h3
`endif

// File: design/pmio_pkg.sv
// types shared by the power manager io port logic
// assumes pmio_params.svh is on the include path
`include "pmio_params.svh"
package pmio_pkg;
	typedef enum logic [3:0] {
		PMIO_ARM_IDLE = 4'h1,
		PMIO_ARM_WAIT = 4'h2,
		PMIO_ARM_SHUT = 4'h4,
		PMIO_ARM_DONE = 4'h8
	} pmio_arm_e;
	typedef struct packed {
		logic [1:0] power_key_mode_sel;
		logic power_key_irq_mask;
		logic charger_wake_mask;
		logic long_press_shutdown_en;
		logic dual_pin_shutdown_en;
		logic host_shutdown_fast_sel;
		logic key_shutdown_fast_sel;
		logic soft_reset_sel;
		logic monitor_reset_en;
		logic sys_pin_function;
		logic sys_pin_polarity;
		logic sys_pin_wake_en;
		logic output_driver_type;
		logic [1:0] reset_trigger_sel;
	} pmio_cfg_s;
	typedef struct packed {
		logic deep_off_state;
		logic shipping_state;
		logic active_state;
		logic sequencer_busy;
		logic otp_configured;
		logic regulator_out_of_range;
		logic external_wake_indication;
		logic system_domain_up;
		logic power_domain_up;
		logic leaving_reset_state;
	} pmio_sys_s;
endpackage

// File: design/pmio_sync_deb.sv
// two-flop synchroniser followed by a level debouncer
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pmio_sync_deb #(
	parameter int DEB_CYCLES = 16,
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic pin_in,
	output logic sync_out,
	output logic deb_out
);
	localparam int CW = $clog2(DEB_CYCLES + 1);
	logic meta_ff;
	logic sync_ff;
	logic deb_ff;
	logic [CW-1:0] cnt_ff;
	// meta_ff is read only by sync_ff
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			meta_ff <= RESET_LEVEL;
			sync_ff <= RESET_LEVEL;
		end
		else
		begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			deb_ff <= RESET_LEVEL;
			cnt_ff <= '0;
		end
		else if (sync_ff == deb_ff)
			cnt_ff <= '0;
		else if (cnt_ff == CW'(DEB_CYCLES - 1))
		begin
			deb_ff <= sync_ff;
			cnt_ff <= '0;
		end
		else
			cnt_ff <= cnt_ff + 1'b1;
	end
	assign sync_out = sync_ff;
	assign deb_out = deb_ff;
endmodule
`default_nettype wire

// File: design/pmio_ports.sv
// power manager io port control: power key, charger wake, hardware
// shutdown inputs, reset output timer and system enable pin
// assumes a 10 MHz ref_clk and that the sequencer reports its state
`timescale 1ns/1ps
`default_nettype none
module pmio_ports
	import pmio_pkg::*;
#(
	parameter int KEY_PRESS_CYC = `PMIO_KEY_PRESS_MS * `PMIO_CYC_PER_MS,
	parameter int LONG_PRESS_SHUTDOWN_TIME_CYC = `PMIO_LONG_PRESS_SHUTDOWN_TIME_MS * `PMIO_CYC_PER_MS,
	parameter int ARM_WAIT_CYC = `PMIO_ARM_WAIT_MS * `PMIO_CYC_PER_MS,
	parameter int MONITOR_RESET_EN_CYC = `PMIO_MONITOR_RESET_EN_MS * `PMIO_CYC_PER_MS,
	parameter int RST_MAX_CYC = `PMIO_RST_MAX_MS * `PMIO_CYC_PER_MS,
	parameter int DEB_CYCLES = `PMIO_DEB_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire pmio_pkg::pmio_cfg_s cfg,
	input wire pmio_pkg::pmio_sys_s sys,
	input wire logic [31:0] reset_release_cycles,
	input wire logic power_key_n,
	input wire logic charger_wakeup_in,
	input wire logic emergency_off_in_n,
	input wire logic host_shutdown_in_n,
	input wire logic dual_pin_a_n,
	input wire logic dual_pin_b_n,
	input wire logic system_enable_pin,
	input wire logic key_lock_clear,
	input wire logic key_reset_clear,
	input wire logic shutdown_fault_clear,
	input wire logic sw_system_enable_wr,
	input wire logic sw_system_enable_val,
	input wire logic interrupt_req_n,
	output logic power_key_level,
	output logic power_key_event,
	output logic power_key_irq,
	output logic charger_wake_event,
	output logic charger_wake_irq,
	output logic sys_pin_irq,
	output logic wakeup_req,
	output logic shipping_exit,
	output logic key_lock,
	output logic system_domain_en,
	output logic standby_req,
	output logic shutdown_fault,
	output logic key_reset_fault,
	output logic nmi_req,
	output logic fast_shutdown_req,
	output logic seq_shutdown_req,
	output logic seq_shutdown_fast,
	output logic sys_power_down_req,
	output logic reset_out_n_o,
	output logic reset_out_n_oe,
	output logic interrupt_out_n_o,
	output logic interrupt_out_n_oe,
	output logic pm_ports_oe
);
	localparam int KCW = 32;
	logic key_deb;
	logic chg_sync;
	logic chg_dly_ff;
	logic off_sync;
	logic off_unused;
	logic hsd_deb;
	logic dpa_deb;
	logic dpb_deb;
	logic sys_sync;
	logic sys_deb;
	logic key_dly_ff;
	logic sys_act_dly_ff;
	logic [KCW-1:0] press_cnt_ff;
	logic long_seen_ff;
	logic [KCW-1:0] dual_cnt_ff;
	logic [KCW-1:0] arm_cnt_ff;
	logic [KCW-1:0] rst_cnt_ff;
	logic [KCW-1:0] mon_cnt_ff;
	logic rst_hold_ff;
	logic rst_run_ff;
	logic long_off_ff;
	pmio_arm_e arm_ff;
	pmio_arm_e nxt_arm;

	// each async pin goes through two flops before any logic
	pmio_sync_deb #(.DEB_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_key
	(
		.ref_clk(ref_clk), .reset(reset), .pin_in(power_key_n),
		.sync_out(), .deb_out(key_deb)
	);
	pmio_sync_deb #(.DEB_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b0)) u_chg
	(
		.ref_clk(ref_clk), .reset(reset), .pin_in(charger_wakeup_in),
		.sync_out(chg_sync), .deb_out()
	);
	// emergency off is used undebounced, only synchronised
	pmio_sync_deb #(.DEB_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_off
	(
		.ref_clk(ref_clk), .reset(reset), .pin_in(emergency_off_in_n),
		.sync_out(off_sync), .deb_out(off_unused)
	);
	pmio_sync_deb #(.DEB_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_hsd
	(
		.ref_clk(ref_clk), .reset(reset), .pin_in(host_shutdown_in_n),
		.sync_out(), .deb_out(hsd_deb)
	);
	pmio_sync_deb #(.DEB_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_dpa
	(
		.ref_clk(ref_clk), .reset(reset), .pin_in(dual_pin_a_n),
		.sync_out(), .deb_out(dpa_deb)
	);
	pmio_sync_deb #(.DEB_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_dpb
	(
		.ref_clk(ref_clk), .reset(reset), .pin_in(dual_pin_b_n),
		.sync_out(), .deb_out(dpb_deb)
	);
	pmio_sync_deb #(.DEB_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b0)) u_sys
	(
		.ref_clk(ref_clk), .reset(reset), .pin_in(system_enable_pin),
		.sync_out(sys_sync), .deb_out(sys_deb)
	);

	logic key_on;
	logic key_fall;
	logic key_rise;
	logic chg_rise;
	logic sys_act;
	logic sys_assert;
	logic sys_release;
	logic long_hit;
	logic short_rel;
	logic key_sd_hit;
	logic dual_low;
	logic dual_hit;
	logic ev_key;
	logic key_wake;
	logic rst_trig;
	logic seq_idle;
	logic mode00;

	assign key_on = ~key_deb;
	assign key_fall = key_on & key_dly_ff;
	assign key_rise = ~key_on & ~key_dly_ff;
	assign chg_rise = chg_sync & ~chg_dly_ff;
	assign sys_act = sys_deb ^ cfg.sys_pin_polarity;
	assign sys_assert = cfg.sys_pin_function & sys_act & ~sys_act_dly_ff;
	assign sys_release = cfg.sys_pin_function & ~sys_act & sys_act_dly_ff;
	assign seq_idle = ~sys.sequencer_busy;
	assign mode00 = cfg.power_key_mode_sel == `PMIO_MODE_EDGE;
	assign long_hit = key_on & (press_cnt_ff == KCW'(KEY_PRESS_CYC - 1));
	assign short_rel = key_rise & ~long_seen_ff;
	assign key_sd_hit = key_on &
		(press_cnt_ff == KCW'(KEY_PRESS_CYC + LONG_PRESS_SHUTDOWN_TIME_CYC - 1));
	assign dual_low = ~dpa_deb & ~dpb_deb;
	assign dual_hit = dual_low &
		(dual_cnt_ff == KCW'(KEY_PRESS_CYC + LONG_PRESS_SHUTDOWN_TIME_CYC - 1));
	// shipping state swallows key events
	assign ev_key = ~sys.shipping_state &
		(mode00 ? key_fall : (short_rel | long_hit));
	// lock lets only a long press wake mask ignored off mode 00
	assign key_wake = sys.deep_off_state &
		(key_lock ? long_hit : ev_key) &
		(~mode00 | ~cfg.power_key_irq_mask);

	// edge history
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			// idle key is released, so no false release edge after reset
			key_dly_ff <= 1'b1;
			chg_dly_ff <= 1'b0;
			sys_act_dly_ff <= 1'b0;
		end
		else
		begin
			key_dly_ff <= ~key_on;
			chg_dly_ff <= chg_sync;
			sys_act_dly_ff <= sys_act;
		end
	end

	// press timers count from debounced press, clear to zero on release
	always_ff @(posedge ref_clk)
	begin
		if (reset | ~key_on)
			press_cnt_ff <= '0;
		else if (press_cnt_ff != '1)
			press_cnt_ff <= press_cnt_ff + 1'b1;
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset | ~dual_low)
			dual_cnt_ff <= '0;
		else if (dual_cnt_ff != '1)
			dual_cnt_ff <= dual_cnt_ff + 1'b1;
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset | key_fall)
			long_seen_ff <= 1'b0;
		else if (long_hit)
			long_seen_ff <= 1'b1;
	end

	// key status, events and wake requests
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			power_key_level <= 1'b0;
			power_key_event <= 1'b0;
			power_key_irq <= 1'b0;
			charger_wake_event <= 1'b0;
			charger_wake_irq <= 1'b0;
			sys_pin_irq <= 1'b0;
			wakeup_req <= 1'b0;
			shipping_exit <= 1'b0;
		end
		else
		begin
			power_key_level <= key_on;
			power_key_event <= ev_key;
			power_key_irq <= ev_key & ~cfg.power_key_irq_mask;
			charger_wake_event <= chg_rise & ~sys.shipping_state;
			charger_wake_irq <= chg_rise & ~sys.shipping_state &
				~cfg.charger_wake_mask;
			sys_pin_irq <= sys_assert & seq_idle;
			wakeup_req <= key_wake |
				(sys.deep_off_state & chg_rise & ~cfg.charger_wake_mask) |
				(sys.deep_off_state & sys_assert & seq_idle &
				cfg.sys_pin_wake_en);
			shipping_exit <= sys.shipping_state &
				(key_fall | chg_rise);
		end
	end

	// key lock: set wins over host clear
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			key_lock <= 1'b0;
		else if (~sys.shipping_state & ~mode00 & long_hit)
			key_lock <= 1'b1;
		else if (key_lock_clear)
			key_lock <= 1'b0;
		else if (sys.deep_off_state & wakeup_req)
			key_lock <= 1'b0;
	end

	// system domain enable and standby
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			system_domain_en <= 1'b0;
			standby_req <= 1'b0;
			long_off_ff <= 1'b0;
			sys_power_down_req <= 1'b0;
		end
		else
		begin
			sys_power_down_req <= 1'b0;
			if (sys.shipping_state)
				standby_req <= standby_req;
			else if (long_off_ff & key_fall)
			begin
				system_domain_en <= 1'b1;
				standby_req <= 1'b0;
				long_off_ff <= 1'b0;
			end
			else if (long_hit & (cfg.power_key_mode_sel ==
				`PMIO_MODE_OFF || cfg.power_key_mode_sel ==
				`PMIO_MODE_STBY))
			begin
				system_domain_en <= 1'b0;
				standby_req <= 1'b0;
				long_off_ff <= 1'b1;
				sys_power_down_req <= 1'b1;
			end
			else if (short_rel &
				(cfg.power_key_mode_sel == `PMIO_MODE_STBY))
			begin
				system_domain_en <= 1'b0;
				standby_req <= 1'b1;
				sys_power_down_req <= 1'b1;
			end
			else if (seq_idle)
			begin
				if (sys_assert)
					system_domain_en <= 1'b1;
				else if (sys_release)
				begin
					system_domain_en <= 1'b0;
					sys_power_down_req <= 1'b1;
				end
				else if (sw_system_enable_wr)
				begin
					system_domain_en <= sw_system_enable_val;
					sys_power_down_req <= ~sw_system_enable_val;
				end
			end
		end
	end

	// armed long-press reset
	always_comb
	begin
		nxt_arm = arm_ff;
		case (arm_ff)
			PMIO_ARM_IDLE:
				if ((cfg.long_press_shutdown_en & key_sd_hit) |
					(cfg.dual_pin_shutdown_en & dual_hit))
					nxt_arm = PMIO_ARM_WAIT;
			PMIO_ARM_WAIT:
				if (key_reset_clear)
					nxt_arm = PMIO_ARM_IDLE;
				else if (arm_cnt_ff == KCW'(ARM_WAIT_CYC - 1))
					nxt_arm = PMIO_ARM_SHUT;
			PMIO_ARM_SHUT:
				nxt_arm = PMIO_ARM_DONE;
			PMIO_ARM_DONE:
				if (sys.leaving_reset_state)
					nxt_arm = PMIO_ARM_IDLE;
			default:
				nxt_arm = PMIO_ARM_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			arm_ff <= PMIO_ARM_IDLE;
		else
			arm_ff <= nxt_arm;
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset | (arm_ff != PMIO_ARM_WAIT))
			arm_cnt_ff <= '0;
		else
			arm_cnt_ff <= arm_cnt_ff + 1'b1;
	end

	// faults and shutdown requests; a set beats a clear
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			shutdown_fault <= 1'b0;
			key_reset_fault <= 1'b0;
			nmi_req <= 1'b0;
			fast_shutdown_req <= 1'b0;
			seq_shutdown_req <= 1'b0;
			seq_shutdown_fast <= 1'b0;
		end
		else
		begin
			fast_shutdown_req <= ~off_sync;
			seq_shutdown_req <= ~hsd_deb | (arm_ff == PMIO_ARM_SHUT);
			seq_shutdown_fast <= (~hsd_deb & cfg.host_shutdown_fast_sel) |
				((arm_ff == PMIO_ARM_SHUT) &
				cfg.key_shutdown_fast_sel);
			if (~off_sync | ~hsd_deb)
				shutdown_fault <= 1'b1;
			else if (shutdown_fault_clear)
				shutdown_fault <= 1'b0;
			if (nxt_arm == PMIO_ARM_WAIT && arm_ff == PMIO_ARM_IDLE)
				key_reset_fault <= 1'b1;
			else if (key_reset_clear)
				key_reset_fault <= 1'b0;
			nmi_req <= nxt_arm == PMIO_ARM_WAIT &&
				arm_ff == PMIO_ARM_IDLE;
		end
	end

	// reset output hold and release timer
	assign rst_trig =
		(cfg.reset_trigger_sel == `PMIO_TRG_WAKE) ?
			sys.external_wake_indication :
		(cfg.reset_trigger_sel == `PMIO_TRG_SYSUP) ?
			sys.system_domain_up :
		(cfg.reset_trigger_sel == `PMIO_TRG_PWRUP) ?
			sys.power_domain_up : sys.leaving_reset_state;
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			mon_cnt_ff <= '0;
		else if (cfg.monitor_reset_en & sys.regulator_out_of_range)
			mon_cnt_ff <= KCW'(MONITOR_RESET_EN_CYC);
		else if (mon_cnt_ff != '0)
			mon_cnt_ff <= mon_cnt_ff - 1'b1;
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rst_hold_ff <= 1'b1;
			rst_run_ff <= 1'b0;
			rst_cnt_ff <= '0;
		end
		else if (sys.shipping_state | ~off_sync | ~hsd_deb |
			(arm_ff == PMIO_ARM_SHUT) | (mon_cnt_ff != '0) |
			(cfg.soft_reset_sel & sys_release & seq_idle))
		begin
			rst_hold_ff <= 1'b1;
			rst_run_ff <= 1'b0;
			rst_cnt_ff <= '0;
		end
		else if (rst_hold_ff & ~rst_run_ff & rst_trig)
			rst_run_ff <= 1'b1;
		else if (rst_run_ff)
		begin
			if (rst_cnt_ff >= reset_release_cycles ||
				rst_cnt_ff >= KCW'(RST_MAX_CYC - 1))
			begin
				rst_hold_ff <= 1'b0;
				rst_run_ff <= 1'b0;
			end
			else
				rst_cnt_ff <= rst_cnt_ff + 1'b1;
		end
	end

	// pin drivers: out of reset, open drain drives only the low level
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			reset_out_n_o <= 1'b0;
			reset_out_n_oe <= 1'b1;
			interrupt_out_n_o <= 1'b1;
			interrupt_out_n_oe <= 1'b1;
			pm_ports_oe <= 1'b0;
		end
		else
		begin
			reset_out_n_o <= ~rst_hold_ff;
			reset_out_n_oe <= ~cfg.output_driver_type | rst_hold_ff;
			interrupt_out_n_o <= interrupt_req_n;
			interrupt_out_n_oe <= ~cfg.output_driver_type |
				~interrupt_req_n;
			pm_ports_oe <= sys.otp_configured;
		end
	end
endmodule
`default_nettype wire

// File: verif/pmio_ports_checker.sv
// timing checks on the pins of the power manager io port block
// assumes one ref_clk domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "pmio_params.svh"
module pmio_ports_checker
	import pmio_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire pmio_pkg::pmio_cfg_s cfg,
	input wire pmio_pkg::pmio_sys_s sys,
	input wire logic [31:0] reset_release_cycles,
	input wire logic charger_wakeup_in,
	input wire logic emergency_off_in_n,
	input wire logic host_shutdown_in_n,
	input wire logic power_key_event,
	input wire logic power_key_irq,
	input wire logic charger_wake_event,
	input wire logic sys_pin_irq,
	input wire logic wakeup_req,
	input wire logic key_lock,
	input wire logic system_domain_en,
	input wire logic shutdown_fault,
	input wire logic seq_shutdown_req,
	input wire logic reset_out_n_o,
	input wire logic reset_out_n_oe
);
	logic [31:0] low_cnt_ff;
	// cleared in reset so the count never starts from an unknown
	always_ff @(posedge ref_clk)
		low_cnt_ff <= (reset | reset_out_n_o) ? 32'h0 : low_cnt_ff + 32'h1;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_evt_once;
		power_key_event |=> !power_key_event;
	endproperty
	a_evt_once: assert property (p_evt_once) else $error("key event long");
	property p_lock_evt;
		$rose(key_lock) |-> power_key_event;
	endproperty
	a_lock_evt: assert property (p_lock_evt) else $error("lock w/o event");
	property p_off_clear;
		$rose(key_lock) && cfg.power_key_mode_sel == `PMIO_MODE_OFF
			|-> ##[0:2] !system_domain_en;
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("system_enable_pin kept");
	property p_mask;
		cfg.power_key_irq_mask |-> !power_key_irq;
	endproperty
	a_mask: assert property (p_mask) else $error("masked key irq");
	property p_ship;
		sys.shipping_state |-> !power_key_event;
	endproperty
	a_ship: assert property (p_ship) else $error("key event shipping");
	property p_chg_sync;
		$rose(charger_wakeup_in) |-> !charger_wake_event ##1 !charger_wake_event;
	endproperty
	a_chg_sync: assert property (p_chg_sync) else $error("charger unsynced");
	property p_emerg;
		$fell(emergency_off_in_n) |-> ##[1:6] (shutdown_fault && !reset_out_n_o);
	endproperty
	a_emerg: assert property (p_emerg) else $error("emergency off slow");
	property p_host_sd;
		$fell(host_shutdown_in_n) |-> ##[2:40] (shutdown_fault && seq_shutdown_req);
	endproperty
	a_host_sd: assert property (p_host_sd) else $error("host shutdown lost");
	property p_sys_irq;
		sys_pin_irq |-> ##[0:1] system_domain_en;
	endproperty
	a_sys_irq: assert property (p_sys_irq) else $error("irq w/o system_enable_pin");
	property p_quiet;
		$fell(system_domain_en) |-> !sys_pin_irq && !wakeup_req;
	endproperty
	a_quiet: assert property (p_quiet) else $error("noisy power down");
	property p_rel_time;
		$rose(reset_out_n_o) |-> low_cnt_ff + 32'h2 >= reset_release_cycles;
	endproperty
	a_rel_time: assert property (p_rel_time) else $error("reset short");
	property p_od;
		cfg.output_driver_type |-> reset_out_n_oe == !reset_out_n_o;
	endproperty
	a_od: assert property (p_od) else $error("open drain drive");
	cover property ($rose(key_lock));
	cover property ($fell(system_domain_en));
	cover property ($rose(seq_shutdown_req));
endmodule
bind pmio_ports pmio_ports_checker pmio_ports_checker_i (.ref_clk, .reset,
	.cfg, .sys, .reset_release_cycles, .charger_wakeup_in, .emergency_off_in_n,
	.host_shutdown_in_n, .power_key_event, .power_key_irq, .charger_wake_event,
	.sys_pin_irq, .wakeup_req, .key_lock, .system_domain_en, .shutdown_fault,
	.seq_shutdown_req, .reset_out_n_o, .reset_out_n_oe);
`default_nettype wire

// File: verif/pmio_far_model.sv
// far side: push button, companion charger and host clear pulses
// assumes callers enter its tasks just after a rising ref_clk edge
`timescale 1ns/1ps
`default_nettype none
module pmio_far_model (
	input wire logic ref_clk,
	output logic power_key_n,
	output logic charger_wakeup_in,
	output logic key_lock_clear,
	output logic key_reset_clear
);
	initial
	begin
		power_key_n = 1'b1;
		charger_wakeup_in = 1'b0;
		key_lock_clear = 1'b0;
		key_reset_clear = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#10;
	endtask
	// contact bounce on make, so the debouncer is really exercised
	task automatic key(input logic up);
		if (!up)
			repeat (3)
			begin
				power_key_n = 1'b0;
				step(1);
				power_key_n = 1'b1;
				step(1);
			end
		power_key_n = up;
	endtask
	task automatic plug();
		charger_wakeup_in = 1'b1;
		step(8);
		charger_wakeup_in = 1'b0;
	endtask
	task automatic clear(input logic lock);
		if (lock)
			key_lock_clear = 1'b1;
		else
			key_reset_clear = 1'b1;
		step(1);
		key_lock_clear = 1'b0;
		key_reset_clear = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: verif/pmio_ports_tb.sv
// self-checking bench for the power manager io port logic
// assumes the far-side model drives the key and charger pins
`timescale 1ns/1ps
`default_nettype none
`include "pmio_params.svh"
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
	n_mismatch++; $display("wrong value %s expected %h seen %h", nm, e, a); \
	end end
module pmio_ports_tb;
	import pmio_pkg::*;
	localparam int KP = 100;
	localparam int SD = 50;
	localparam int AW = 60;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	pmio_cfg_s cfg = '0;
	pmio_sys_s sys = '0;
	logic [31:0] reset_release_cycles = 32'h1e;
	logic emergency_off_in_n = 1'b1;
	logic host_shutdown_in_n = 1'b1;
	logic system_enable_pin = 1'b0;
	logic shutdown_fault_clear = 1'b0;
	logic dual_pin_a_n = 1'b1;
	logic dual_pin_b_n = 1'b1;
	logic sw_system_enable_wr = 1'b0;
	logic sw_system_enable_val = 1'b0;
	logic interrupt_req_n = 1'b1;
	logic [9:0] seen = '0;
	int comparisons = 0;
	int n_mismatch = 0;
	int cycles = 0;
	wire logic power_key_n, charger_wakeup_in, key_lock_clear, key_reset_clear;
	wire logic power_key_level, power_key_event, power_key_irq, nmi_req;
	wire logic charger_wake_event, charger_wake_irq, sys_pin_irq, wakeup_req;
	wire logic shipping_exit, key_lock, system_domain_en, standby_req;
	wire logic shutdown_fault, key_reset_fault, fast_shutdown_req;
	wire logic seq_shutdown_req, seq_shutdown_fast, sys_power_down_req;
	wire logic reset_out_n_o, interrupt_out_n_o, pm_ports_oe;
	pmio_far_model pmio_far_model_i (.ref_clk, .power_key_n,
		.charger_wakeup_in, .key_lock_clear, .key_reset_clear);
	pmio_ports #(.KEY_PRESS_CYC(KP), .LONG_PRESS_SHUTDOWN_TIME_CYC(SD), .ARM_WAIT_CYC(AW),
		.MONITOR_RESET_EN_CYC(20), .RST_MAX_CYC(200)) pmio_ports_i (.ref_clk, .reset,
		.cfg, .sys, .reset_release_cycles, .power_key_n, .charger_wakeup_in,
		.emergency_off_in_n, .host_shutdown_in_n, .dual_pin_a_n,
		.dual_pin_b_n, .system_enable_pin, .key_lock_clear,
		.key_reset_clear, .shutdown_fault_clear, .sw_system_enable_wr,
		.sw_system_enable_val, .interrupt_req_n, .power_key_level,
		.power_key_event, .power_key_irq, .charger_wake_event, .charger_wake_irq,
		.sys_pin_irq, .wakeup_req, .shipping_exit, .key_lock, .system_domain_en,
		.standby_req, .shutdown_fault, .key_reset_fault, .nmi_req,
		.fast_shutdown_req, .seq_shutdown_req, .seq_shutdown_fast,
		.sys_power_down_req, .reset_out_n_o, .reset_out_n_oe(),
		.interrupt_out_n_o, .interrupt_out_n_oe(), .pm_ports_oe);
	always #50 ref_clk = ~ref_clk;
	// pulses except seq_shutdown_req are one cycle wide, so they are latched until the next clr
	always @(posedge ref_clk)
		seen <= seen | {power_key_event, power_key_irq, charger_wake_event,
			charger_wake_irq, sys_pin_irq, wakeup_req, shipping_exit, nmi_req,
			sys_power_down_req, seq_shutdown_req};
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic run(input int n);
		repeat (n) @(posedge ref_clk);
		#10;
	endtask
	task automatic tap(input int n);
		pmio_far_model_i.key(1'b0);
		run(n);
		pmio_far_model_i.key(1'b1);
		run(30);
	endtask
	initial
	begin
		cfg.output_driver_type = 1'b1;
		cfg.reset_trigger_sel = `PMIO_TRG_SYSUP;
		cfg.sys_pin_function = 1'b1;
		run(4);
		reset = 1'b0;
		`CHK("rst", 1'b0, reset_out_n_o)
		`CHK("irq pin", 1'b1, interrupt_out_n_o)
		`CHK("ports oe", 1'b0, pm_ports_oe)
		sys.otp_configured = 1'b1;
		run(10);
		`CHK("ports oe", 1'b1, pm_ports_oe)
		`CHK("rst", 1'b0, reset_out_n_o)
		sys.system_domain_up = 1'b1;
		run(20);
		`CHK("rst", 1'b0, reset_out_n_o)
		run(20);
		`CHK("rst", 1'b1, reset_out_n_o)
		seen = '0;
		system_enable_pin = 1'b1;
		run(30);
		`CHK("system_enable_pin", 1'b1, system_domain_en)
		`CHK("pulses", 10'h020, seen)
		sys.sequencer_busy = 1'b1;
		system_enable_pin = 1'b0;
		run(30);
		`CHK("system_enable_pin", 1'b1, system_domain_en)
		system_enable_pin = 1'b1;
		run(30);
		sys.sequencer_busy = 1'b0;
		run(2);
		seen = '0;
		system_enable_pin = 1'b0;
		run(30);
		`CHK("system_enable_pin", 1'b0, system_domain_en)
		`CHK("pulses", 10'h002, seen)
		system_enable_pin = 1'b1;
		run(30);
		seen = '0;
		pmio_far_model_i.key(1'b0);
		run(30);
		`CHK("key level", 1'b1, power_key_level)
		`CHK("pulses", 10'h300, seen)
		pmio_far_model_i.key(1'b1);
		run(30);
		`CHK("pulses", 10'h300, seen)
		cfg.power_key_irq_mask = 1'b1;
		seen = '0;
		tap(30);
		`CHK("pulses", 10'h200, seen)
		cfg.power_key_irq_mask = 1'b0;
		cfg.power_key_mode_sel = `PMIO_MODE_LOCK;
		seen = '0;
		pmio_far_model_i.key(1'b0);
		run(60);
		`CHK("pulses", 10'h000, seen)
		pmio_far_model_i.key(1'b1);
		run(30);
		`CHK("pulses", 10'h300, seen)
		`CHK("lock", 1'b0, key_lock)
		seen = '0;
		tap(KP + 30);
		`CHK("lock", 1'b1, key_lock)
		`CHK("pulses", 10'h300, seen)
		pmio_far_model_i.clear(1'b1);
		run(2);
		`CHK("lock", 1'b0, key_lock)
		cfg.power_key_mode_sel = `PMIO_MODE_OFF;
		tap(KP + 30);
		`CHK("lock", 1'b1, key_lock)
		`CHK("system_enable_pin", 1'b0, system_domain_en)
		tap(40);
		`CHK("system_enable_pin", 1'b1, system_domain_en)
		cfg.power_key_mode_sel = `PMIO_MODE_STBY;
		seen = '0;
		tap(40);
		`CHK("en stby", 2'b01, {system_domain_en, standby_req})
		`CHK("key event", 1'b1, seen[9])
		pmio_far_model_i.key(1'b0);
		run(KP + 30);
		`CHK("en stby", 2'b00, {system_domain_en, standby_req})
		pmio_far_model_i.key(1'b1);
		run(30);
		cfg.power_key_mode_sel = `PMIO_MODE_LOCK;
		cfg.power_key_irq_mask = 1'b1;
		sys.deep_off_state = 1'b1;
		seen = '0;
		tap(40);
		`CHK("wake", 1'b0, seen[4])
		tap(KP + 30);
		`CHK("wake", 1'b1, seen[4])
		sys.deep_off_state = 1'b0;
		cfg.power_key_irq_mask = 1'b0;
		seen = '0;
		pmio_far_model_i.plug();
		run(10);
		`CHK("pulses", 10'h0c0, seen)
		cfg.charger_wake_mask = 1'b1;
		seen = '0;
		pmio_far_model_i.plug();
		run(10);
		`CHK("pulses", 10'h080, seen)
		cfg.charger_wake_mask = 1'b0;
		sys.shipping_state = 1'b1;
		seen = '0;
		tap(30);
		`CHK("pulses", 10'h008, seen)
		seen = '0;
		pmio_far_model_i.plug();
		run(10);
		`CHK("ship exit", 1'b1, seen[3])
		sys.shipping_state = 1'b0;
		emergency_off_in_n = 1'b0;
		run(8);
		`CHK("emerg", 3'b110, {shutdown_fault, fast_shutdown_req,
			reset_out_n_o})
		emergency_off_in_n = 1'b1;
		run(5);
		shutdown_fault_clear = 1'b1;
		run(1);
		shutdown_fault_clear = 1'b0;
		run(2);
		`CHK("sd fault", 1'b0, shutdown_fault)
		cfg.host_shutdown_fast_sel = 1'b1;
		host_shutdown_in_n = 1'b0;
		run(45);
		`CHK("host sd", 3'b111, {shutdown_fault, seq_shutdown_req,
			seq_shutdown_fast})
		host_shutdown_in_n = 1'b1;
		run(30);
		cfg.power_key_mode_sel = `PMIO_MODE_EDGE;
		cfg.long_press_shutdown_en = 1'b1;
		seen = '0;
		pmio_far_model_i.key(1'b0);
		run(KP + SD + 40);
		`CHK("key fault", 1'b1, key_reset_fault)
		`CHK("nmi", 1'b1, seen[2])
		pmio_far_model_i.key(1'b1);
		pmio_far_model_i.clear(1'b0);
		run(AW + 20);
		`CHK("key fault", 1'b0, key_reset_fault)
		`CHK("shutdown", 1'b0, seen[0])
		// no release trigger, so the reset output must stay held
		sys.system_domain_up = 1'b0;
		tap(KP + SD + 40);
		run(AW);
		`CHK("shutdown", 1'b1, seen[0])
		`CHK("rst", 1'b0, reset_out_n_o)
		interrupt_req_n = 1'b0;
		run(2);
		`CHK("irq pin", 1'b0, interrupt_out_n_o)
		interrupt_req_n = 1'b1;
		sw_system_enable_wr = 1'b1;
		run(1);
		sw_system_enable_wr = 1'b0;
		run(2);
		`CHK("system_enable_pin", 1'b0, system_domain_en)
		pmio_far_model_i.clear(1'b0);
		sys.leaving_reset_state = 1'b1;
		run(2);
		sys.leaving_reset_state = 1'b0;
		`CHK("key fault", 1'b0, key_reset_fault)
		cfg.long_press_shutdown_en = 1'b0;
		cfg.dual_pin_shutdown_en = 1'b1;
		dual_pin_a_n = 1'b0;
		dual_pin_b_n = 1'b0;
		run(KP + SD + 40);
		`CHK("key fault", 1'b1, key_reset_fault)
		dual_pin_a_n = 1'b1;
		dual_pin_b_n = 1'b1;
		end_of_test();
	end
endmodule
`default_nettype wire
